// file: design/meter_host_register_port.sv
// Host register port: two-wire slave and four-wire slave on shared pins.
// Assumes acc_rdata and acc_size answer acc_addr in the same cycle.
//
// What the document requires
// [RULE_01] Two-wire slave works with serial clocks up to 400 kHz.
// [RULE_02] Master writes: start, address byte, 16-bit register address, value.
// [RULE_03] Answer only bus address 0111000b; lowest bit gives direction.
// [RULE_04] Acknowledge every byte received during a two-wire write.
// [RULE_05] Master sends stop after the last value byte is acknowledged.
// [RULE_06] Addresses and contents travel most significant bit first.
// [RULE_07] Read first sets the pointer: address byte then 16-bit address.
// [RULE_08] Repeated start with 0x71, acknowledged, then register bytes follow.
// [RULE_09] Master withholds acknowledge on the last byte, then stops.
// [RULE_10] Harmonic area: acknowledged last byte advances pointer, next register streams.
// [RULE_11] Master should stop bursts before passing the harmonic area end.
// [RULE_12] Both protocols share data and clock pins; one at a time.
// [RULE_13] Four-wire input sampled on rising edge; output shifted on falling.
// [RULE_14] Four-wire slave works with serial clocks up to 2.5 MHz.
// [RULE_15] Four-wire output floats unless the device is sending data.
// [RULE_16] Select rising mid-transfer aborts and floats the bus.
// [RULE_17] Master should read back registers after writing them.
// [RULE_18] First four-wire byte: lowest bit set means read, rest ignored.
// [RULE_19] Contents start on the falling edge after the last address bit.
// [RULE_20] Select and clock high end the access; data lines float.
// [RULE_21] Three select falls after reset choose four-wire until next reset.
// [RULE_22] Four-wire write: first byte bit zero, address, value, no gaps.
// [RULE_23] Register width decides how many data bytes move.
module meter_host_register_port (
  input  wire logic        core_clk,                          // System clock
  input  wire logic        rst,                               // Sync reset
  input  wire logic        ce,                                // Clock enable
  input  wire logic        scl_sclk,                          // Shared clock pin
  input  wire logic        sda_mosi,                          // Shared data-in pin
  output logic             sda_out,                           // Data pin level
  output logic             sda_oe,                            // Pulls data low
  input  wire logic        select_or_capture_strobe_pin_n,    // Select, low
  output logic             serial_out_or_capture_data_pin,    // Serial out
  output logic             serial_out_or_capture_data_pin_oe, // Out enable
  output logic             spi_mode,                          // Four-wire chosen
  output logic [15:0]      acc_addr,                          // Register pointer
  output logic [31:0]      acc_wdata,                         // Write value
  output logic             acc_wr,                            // Write pulse
  output logic             acc_rd,                            // Read pulse
  input  wire logic [31:0] acc_rdata,                         // Read value
  input  wire logic [1:0]  acc_size                           // Width code
);

  typedef enum logic [2:0] {
    I_IDLE,
    I_RX,
    I_RX_ACK,
    I_TX_LOAD,
    I_TX,
    I_TX_ACK
  } i2c_state_type;

  typedef struct packed {
    logic          scl1;
    logic          scl2;
    logic          scl3;
    logic          sda1;
    logic          sda2;
    logic          sda3;
    logic          ss1;
    logic          ss2;
    logic          ss3;
    logic [1:0]    falls;
    logic          spi_mode;
    logic          rq1;
    logic          rq2;
    logic          rq_seen;
    logic          wq1;
    logic          wq2;
    logic          wq_seen;
    logic          fetch;
    logic          fetch_rd;
    logic [31:0]   spi_word;
    logic [1:0]    spi_size;
    logic [15:0]   acc_addr;
    logic [31:0]   acc_wdata;
    logic          acc_wr;
    logic          acc_rd;
    i2c_state_type st;
    logic [3:0]    bitc;
    logic [2:0]    byte_idx;
    logic [7:0]    sh;
    logic          rd_mode;
    logic          sda_oe;
    logic          sda_out;
    logic [31:0]   word;
    logic [1:0]    tbyte;
  } core_state_type;

  core_state_type r;
  core_state_type next_r;

  logic        spi_req_tgl;
  logic [15:0] spi_req_addr;
  logic        spi_req_rd;
  logic        spi_wr_tgl;
  logic [31:0] spi_wdata;
  logic        link_clear;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        ss_fall;
  logic        byte_in;
  logic        tx_last;

  // ==========================================
  // Link side
  // Select pin clears the link logic without needing a clock edge
  assign link_clear = select_or_capture_strobe_pin_n | ~r.spi_mode; // [RULE_16]

  spi_link_shifter link (
    .sclk     (scl_sclk),
    .clear    (link_clear),
    .mosi     (sda_mosi),
    .word_in  (r.spi_word),
    .size_in  (r.spi_size),
    .req_tgl  (spi_req_tgl),
    .req_addr (spi_req_addr),
    .req_rd   (spi_req_rd),
    .wr_tgl   (spi_wr_tgl),
    .wdata    (spi_wdata),
    .miso     (serial_out_or_capture_data_pin),
    .miso_oe  (serial_out_or_capture_data_pin_oe)
  );

  // ==========================================
  // Pin events, seen after the synchronisers
  assign scl_rise  = r.scl2 & ~r.scl3;
  assign scl_fall  = ~r.scl2 & r.scl3;
  assign bus_start = r.scl2 & r.scl3 & ~r.sda2 & r.sda3;
  assign bus_stop  = r.scl2 & r.scl3 & r.sda2 & ~r.sda3;
  assign ss_fall   = ~r.ss2 & r.ss3;
  assign byte_in   = (r.st == I_RX) && scl_fall && (r.bitc == host_port_pkg::BYTE_BITS);
  assign tx_last   = ({1'b0, r.tbyte} + 3'h1) == host_port_pkg::size_bytes(acc_size);

  // ==========================================
  // Next state
  always_comb
  begin
    logic [7:0] cur;
    logic [7:0] first;
    cur    = host_port_pkg::pick_byte(r.word, acc_size, r.tbyte);
    first  = host_port_pkg::pick_byte(acc_rdata, acc_size, 2'h0);
    next_r = r;
    next_r.acc_wr = 1'b0;
    next_r.acc_rd = 1'b0;
    // Three stages per pin; 400 kHz and 2.5 MHz are far below the core rate
    next_r.scl1 = scl_sclk;                                    // [RULE_01]
    next_r.scl2 = r.scl1;
    next_r.scl3 = r.scl2;
    next_r.sda1 = sda_mosi;
    next_r.sda2 = r.sda1;
    next_r.sda3 = r.sda2;
    next_r.ss1  = select_or_capture_strobe_pin_n;
    next_r.ss2  = r.ss1;
    next_r.ss3  = r.ss2;
    next_r.rq1  = spi_req_tgl;                                 // [RULE_14]
    next_r.rq2  = r.rq1;
    next_r.wq1  = spi_wr_tgl;
    next_r.wq2  = r.wq1;

    // Protocol choice, locked until reset
    if (!r.spi_mode && ss_fall)
    begin
      next_r.falls = r.falls + 2'h1;
      if (r.falls + 2'h1 == host_port_pkg::SEL_FALLS)
        next_r.spi_mode = 1'b1;                                // [RULE_21]
    end

    if (r.spi_mode)
    begin
      next_r.st     = I_IDLE;                                  // [RULE_12]
      next_r.sda_oe = 1'b0;
      if (r.fetch)
      begin
        next_r.spi_word = acc_rdata;
        next_r.spi_size = acc_size;                            // [RULE_23]
        next_r.acc_rd   = r.fetch_rd;
        next_r.fetch    = 1'b0;
      end
      if (r.ss2)
      begin
        next_r.rq_seen = 1'b0;
        next_r.wq_seen = 1'b0;
      end
      else
      begin
        if (r.rq2 != r.rq_seen)
        begin
          next_r.rq_seen  = r.rq2;
          next_r.acc_addr = spi_req_addr;                      // [RULE_19]
          next_r.fetch    = 1'b1;
          next_r.fetch_rd = spi_req_rd;
        end
        if (r.wq2 != r.wq_seen)
        begin
          next_r.wq_seen   = r.wq2;
          next_r.acc_wdata = spi_wdata;                        // [RULE_22]
          next_r.acc_wr    = 1'b1;
        end
      end
    end
    else if (bus_stop)
    begin
      next_r.st     = I_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      next_r.st       = I_RX;
      next_r.bitc     = 4'h0;
      next_r.byte_idx = 3'h0;
      next_r.sda_oe   = 1'b0;
    end
    else
    begin
      case (r.st)
        I_RX:
        begin
          if (scl_rise)
          begin
            next_r.sh   = {r.sh[6:0], r.sda2};                 // [RULE_06]
            next_r.bitc = r.bitc + 4'h1;
          end
          else if (byte_in)
          begin
            next_r.st     = I_RX_ACK;
            next_r.sda_oe = 1'b1;                              // [RULE_04]
            case (r.byte_idx)
              3'h0:
              begin
                next_r.rd_mode = r.sh[0];
                if (r.sh[7:1] != host_port_pkg::DEV_ADDR)      // [RULE_03]
                begin
                  next_r.st     = I_IDLE;
                  next_r.sda_oe = 1'b0;
                end
              end
              3'h1:
                next_r.acc_addr = {r.sh, r.acc_addr[7:0]};     // [RULE_07]
              3'h2:
                next_r.acc_addr = {r.acc_addr[15:8], r.sh};
              default:
              begin
                if (r.byte_idx == host_port_pkg::HDR_BYTES)
                  next_r.acc_wdata = {24'h0, r.sh};
                else
                  next_r.acc_wdata = {r.acc_wdata[23:0], r.sh};
                if (r.byte_idx - host_port_pkg::HDR_BYTES + 3'h1
                    == host_port_pkg::size_bytes(acc_size))    // [RULE_23]
                begin
                  next_r.acc_wr   = 1'b1;
                  next_r.byte_idx = host_port_pkg::HDR_BYTES - 3'h1;
                end
              end
            endcase
          end
        end
        I_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_r.sda_oe = 1'b0;
            next_r.bitc   = 4'h0;
            if (r.rd_mode && r.byte_idx == 3'h0)
              next_r.st = I_TX_LOAD;                           // [RULE_08]
            else
            begin
              next_r.st       = I_RX;
              next_r.byte_idx = r.byte_idx + 3'h1;
            end
          end
        end
        I_TX_LOAD:
        begin
          next_r.word   = acc_rdata;
          next_r.tbyte  = 2'h0;
          next_r.acc_rd = 1'b1;
          next_r.bitc   = 4'h0;
          next_r.st     = I_TX;
          // Drive only while the clock is low
          if (!r.scl2)
            next_r.sda_oe = ~first[7];
        end
        I_TX:
        begin
          if (scl_rise)
            next_r.bitc = r.bitc + 4'h1;
          else if (scl_fall)
          begin
            if (r.bitc == host_port_pkg::BYTE_BITS)
            begin
              next_r.sda_oe = 1'b0;
              next_r.st     = I_TX_ACK;
            end
            else
              next_r.sda_oe = ~cur[3'h7 - r.bitc[2:0]];        // [RULE_06]
          end
        end
        I_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (r.sda2)
              next_r.st = I_IDLE;
            else if (tx_last)
            begin
              next_r.st = I_TX_LOAD;
              if (host_port_pkg::in_harm(r.acc_addr))          // [RULE_10]
                next_r.acc_addr = r.acc_addr + 16'h1;
            end
            else
            begin
              next_r.tbyte = r.tbyte + 2'h1;
              next_r.bitc  = 4'h0;
              next_r.st    = I_TX;
            end
          end
        end
        default:
          next_r.st = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  assign sda_out   = r.sda_out;
  assign sda_oe    = r.sda_oe;
  assign spi_mode  = r.spi_mode;
  assign acc_addr  = r.acc_addr;
  assign acc_wdata = r.acc_wdata;
  assign acc_wr    = r.acc_wr;
  assign acc_rd    = r.acc_rd;

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_mode_sticky: assert property (r.spi_mode |=> r.spi_mode) // [RULE_21]
    else $error("protocol choice lost");

  a_mode_third: assert property ( // [RULE_21]
    $rose(r.spi_mode) |-> ($past(r.falls) + 2'h1) == host_port_pkg::SEL_FALLS)
    else $error("four-wire chosen on wrong select count");

  a_pins_shared: assert property (r.spi_mode |-> !r.sda_oe) // [RULE_12]
    else $error("two-wire drive in four-wire mode");

  a_addr_match: assert property ( // [RULE_03]
    (ce && byte_in && !bus_start && !bus_stop && r.byte_idx == 3'h0 && !r.spi_mode)
      |=> r.sda_oe == ($past(r.sh[7:1]) == host_port_pkg::DEV_ADDR))
    else $error("address byte answered wrongly");

  a_ack_each: assert property ( // [RULE_04]
    (ce && byte_in && !bus_start && !bus_stop && r.byte_idx != 3'h0 && !r.spi_mode)
      |=> r.sda_oe && r.st == I_RX_ACK)
    else $error("received byte not acknowledged");

  a_write_size: assert property ( // [RULE_23]
    (r.acc_wr && !r.spi_mode) |-> ($past(r.byte_idx) - host_port_pkg::HDR_BYTES + 3'h1)
      == host_port_pkg::size_bytes($past(acc_size)))
    else $error("write committed at wrong byte count");

  a_burst_step: assert property ( // [RULE_10]
    (ce && r.st == I_TX_ACK && scl_rise && !r.sda2 && tx_last && !r.spi_mode
      && !bus_start && !bus_stop && host_port_pkg::in_harm(r.acc_addr))
      |=> r.acc_addr == $past(r.acc_addr) + 16'h1)
    else $error("burst pointer did not advance");

  a_sda_quiet_high: assert property ( // [RULE_06]
    (ce && r.st == I_TX && r.scl2 && r.scl3) |=> $stable(r.sda_oe))
    else $error("data changed while clock high");

  a_spi_fetch: assert property ( // [RULE_19]
    (ce && r.spi_mode && !r.ss2 && r.rq2 != r.rq_seen && !r.fetch) ##1 ce
      |=> r.spi_word == $past(acc_rdata))
    else $error("register contents not fetched in time");

endmodule

// file: design/host_port_pkg.sv
// Constants and decode helpers shared by the host register port files.
// Assumes a 100 MHz core clock and a register file answering by address.
package host_port_pkg;

  // ==========================================
  // Addresses and framing
  localparam logic [6:0]  DEV_ADDR     = 7'h38;
  localparam logic [15:0] HARM_FIRST   = 16'he880;
  localparam logic [15:0] HARM_LAST    = 16'he89f;
  localparam logic [1:0]  SEL_FALLS    = 2'h3;
  localparam logic [2:0]  HDR_BYTES    = 3'h3;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [4:0]  SPI_HDR_LAST = 5'h17;
  localparam logic [5:0]  WORD_BITS    = 6'h20;

  // ==========================================
  // Register width codes
  localparam logic [1:0]  SIZE_8       = 2'h0;
  localparam logic [1:0]  SIZE_16      = 2'h1;
  localparam logic [1:0]  SIZE_32      = 2'h2;

  // ==========================================
  // Decoders
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    case (s)
      SIZE_8:  return 3'h1;
      SIZE_16: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  function automatic logic [5:0] size_bits(input logic [1:0] s);
    return {size_bytes(s), 3'h0};
  endfunction

  function automatic logic in_harm(input logic [15:0] a);
    return (a >= HARM_FIRST) && (a <= HARM_LAST);
  endfunction

  // Byte idx of a register, counted from its most significant byte
  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0]  s,
                                           input logic [1:0]  idx);
    logic [2:0]  pos;
    logic [31:0] t;
    pos = size_bytes(s) - 3'h1 - {1'b0, idx};
    t   = w >> {pos, 3'h0};
    return t[7:0];
  endfunction

endpackage

// file: design/spi_link_shifter.sv
// Four-wire shifter running on the link's own serial clock.
// Assumes word_in and size_in from the core are settled half a clock early.
module spi_link_shifter (
  input  wire logic        sclk,     // Link clock
  input  wire logic        clear,    // Async clear, select high
  input  wire logic        mosi,     // Serial data in
  input  wire logic [31:0] word_in,  // Register contents from core
  input  wire logic [1:0]  size_in,  // Register width code from core
  output logic             req_tgl,  // Toggles per address request
  output logic [15:0]      req_addr, // Requested register address
  output logic             req_rd,   // Request is a read
  output logic             wr_tgl,   // Toggles per finished write
  output logic [31:0]      wdata,    // Written value
  output logic             miso,     // Serial data out
  output logic             miso_oe   // Serial out enable
);

  typedef struct packed {
    logic        hdr_done;
    logic        rd;
    logic [4:0]  cnt;
    logic [23:0] hsh;
    logic [15:0] addr;
    logic        req_tgl;
    logic [5:0]  dcnt;
    logic [31:0] wsh;
    logic [31:0] wdata;
    logic        wr_tgl;
    logic        done;
  } rx_type;

  typedef struct packed {
    logic [31:0] sh;
    logic        miso;
    logic        oe;
  } tx_type;

  rx_type rx;
  rx_type next_rx;
  tx_type tx;
  tx_type next_tx;

  // ==========================================
  // Sampling on the rising edge
  always_comb
  begin
    logic [23:0] full;
    logic [5:0]  dn;
    full    = {rx.hsh[22:0], mosi};
    dn      = rx.dcnt + 6'h1;
    next_rx = rx;
    if (!rx.hdr_done)
    begin
      next_rx.hsh = full;
      next_rx.cnt = rx.cnt + 5'h1;
      if (rx.cnt == host_port_pkg::SPI_HDR_LAST)
      begin
        next_rx.hdr_done = 1'b1;
        next_rx.rd       = full[16];                           // [RULE_18]
        next_rx.addr     = full[15:0];
        next_rx.req_tgl  = ~rx.req_tgl;
      end
    end
    else
    begin
      next_rx.wsh = {rx.wsh[30:0], mosi};
      if (dn == host_port_pkg::size_bits(size_in))            // [RULE_23]
      begin
        next_rx.dcnt = 6'h0;
        if (rx.rd)
        begin
          if (host_port_pkg::in_harm(rx.addr))                 // [RULE_10]
          begin
            next_rx.addr    = rx.addr + 16'h1;
            next_rx.req_tgl = ~rx.req_tgl;
          end
        end
        else if (!rx.done)
        begin
          next_rx.wdata  = {rx.wsh[30:0], mosi};               // [RULE_22]
          next_rx.wr_tgl = ~rx.wr_tgl;
          next_rx.done   = 1'b1;
        end
      end
      else
        next_rx.dcnt = dn;
    end
  end

  // ==========================================
  // Driving on the falling edge, MSB first
  always_comb
  begin
    logic [31:0] ld;
    ld      = word_in << (host_port_pkg::WORD_BITS - host_port_pkg::size_bits(size_in));
    next_tx = tx;
    if (rx.hdr_done && rx.rd)
    begin
      if (rx.dcnt == 6'h0)                                     // [RULE_19]
      begin
        next_tx.sh   = ld;
        next_tx.miso = ld[31];
        next_tx.oe   = 1'b1;
      end
      else
      begin
        next_tx.sh   = {tx.sh[30:0], 1'b0};                    // [RULE_13]
        next_tx.miso = tx.sh[30];
      end
    end
  end

  // Select high aborts and floats the output
  always_ff @(posedge sclk or posedge clear)
  begin
    if (clear)
      rx <= '0;                                                // [RULE_16]
    else
      rx <= next_rx;
  end

  always_ff @(negedge sclk or posedge clear)
  begin
    if (clear)
      tx <= '0;                                                // [RULE_20]
    else
      tx <= next_tx;
  end

  assign req_tgl  = rx.req_tgl;
  assign req_addr = rx.addr;
  assign req_rd   = rx.rd;
  assign wr_tgl   = rx.wr_tgl;
  assign wdata    = rx.wdata;
  assign miso     = tx.miso;
  assign miso_oe  = tx.oe;

  // ==========================================
  // Checks
  a_hdr_request: assert property (@(posedge sclk) disable iff (clear) // [RULE_19]
    (!rx.hdr_done && rx.cnt == host_port_pkg::SPI_HDR_LAST)
      |=> rx.hdr_done && (rx.req_tgl != $past(rx.req_tgl)))
    else $error("address not requested after header");

  a_miso_quiet: assert property (@(posedge sclk) disable iff (clear) // [RULE_15]
    !(rx.hdr_done && rx.rd) |-> !tx.oe)
    else $error("serial out driven outside a read");

  a_one_write: assert property (@(posedge sclk) disable iff (clear) // [RULE_22]
    (rx.hdr_done && !rx.rd && !rx.done
      && (rx.dcnt + 6'h1) < host_port_pkg::size_bits(size_in))
      |=> !rx.done && $stable(rx.wr_tgl))
    else $error("write committed before value complete");

endmodule

// file: tb/host_master_model.sv
// Bus master model driving the shared two-wire and four-wire pins.
// Assumes the bench resolves the open-drain data line into sda_in.
module host_master_model (
  output logic     scl,     // Shared serial clock
  output logic     sda_drv, // Data drive, 1 releases
  output logic     sel_n,   // Select, active low
  input wire logic sda_in,  // Resolved data line
  input wire logic so,      // Serial out of device
  input wire logic so_oe    // Serial out enable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 631;
  localparam int H = 203;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    sel_n = 1'b1;
  end
  // ==========================================
  // Two-wire
  task automatic i2c_start;
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic i2c_stop;
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #(2 * Q);
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
                          output logic ack_in);
    logic [8:0] bits;
    logic [8:0] got;
    bits = {tx, ack_out};
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv = bits[i];
      #Q scl = 1'b1;
      #Q got[i] = sda_in;
      #Q scl = 1'b0;
      #Q;
    end
    rx = got[8:1];
    ack_in = ~got[0];
  endtask
  // ==========================================
  // Four-wire
  task automatic sel_pulse;
    #H sel_n = 1'b0;
    #H sel_n = 1'b1;
  endtask
  task automatic spi_frame(input logic [63:0] tx, input int n, output logic [63:0] rx,
                           output logic [63:0] oe);
    rx = '0;
    oe = '0;
    #(2 * H) sel_n = 1'b0;
    for (int i = 63; i > 63 - n; i--)
    begin
      #H scl = 1'b0;
      sda_drv = tx[i];
      #H rx[i] = so_oe ? so : ~so;
      oe[i] = so_oe;
      scl = 1'b1;
    end
    #H sel_n = 1'b1;
    sda_drv = 1'b1;
  endtask
endmodule

// file: tb/meter_host_register_port_tb.sv
// Self-checking bench for the host register port.
// Assumes host_master_model as far side; registers answered here.
module meter_host_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, scl, sda_drv, sel_n, sda_out, sda_oe, so, so_oe, spi_mode;
  logic acc_wr, acc_rd, sda_line;
  logic [15:0] acc_addr, wr_addr;
  logic [31:0] acc_wdata, acc_rdata, wr_data;
  logic [1:0] acc_size;
  int n_errors = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0, cycles = 0;
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  assign acc_rdata = {acc_addr[7:0], acc_addr[15:8], ~acc_addr[7:0], acc_addr[7:0]};
  assign acc_size = (acc_addr[15:8] == 8'he8) ? host_port_pkg::SIZE_32 :
                    (acc_addr[15:12] == 4'h2) ? host_port_pkg::SIZE_8 : host_port_pkg::SIZE_16;
  meter_host_register_port dut (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .scl_sclk(scl), .sda_mosi(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_or_capture_strobe_pin_n(sel_n),
    .serial_out_or_capture_data_pin(so), .serial_out_or_capture_data_pin_oe(so_oe),
    .spi_mode(spi_mode), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_size(acc_size));
  host_master_model m (.scl(scl), .sda_drv(sda_drv), .sel_n(sel_n), .sda_in(sda_line),
    .so(so), .so_oe(so_oe));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (acc_rd)
      rd_cnt++;
    if (acc_wr)
    begin
      wr_cnt++;
      wr_addr = acc_addr;
      wr_data = acc_wdata;
    end
    if (cycles == 80000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic i2c_write_test;
    logic [7:0] d;
    logic a;
    logic [7:0] tx [5] = '{8'h70, 8'h12, 8'h34, 8'ha5, 8'hc3};
    m.i2c_start();
    foreach (tx[i])
    begin
      m.i2c_byte(tx[i], 1'b1, d, a);
      check("write ack", {31'h0, a}, 32'h1);
    end
    m.i2c_stop();
    check("write count", wr_cnt, 32'h1);
    check("write addr", {16'h0, wr_addr}, 32'h1234);
    check("write data", wr_data, 32'ha5c3);
    m.i2c_start();
    m.i2c_byte(8'h52, 1'b1, d, a);
    check("foreign ack", {31'h0, a}, 32'h0);
    m.i2c_stop();
  endtask
  task automatic i2c_burst_test;
    logic [7:0] d;
    logic a;
    logic [7:0] hdr [4] = '{8'h70, 8'he8, 8'h80, 8'h71};
    logic [7:0] exp [8] = '{8'h80, 8'he8, 8'h7f, 8'h80, 8'h81, 8'he8, 8'h7e, 8'h81};
    foreach (hdr[i])
    begin
      if (i == 0 || i == 3)
        m.i2c_start();
      m.i2c_byte(hdr[i], 1'b1, d, a);
      check("read ack", {31'h0, a}, 32'h1);
    end
    foreach (exp[i])
    begin
      m.i2c_byte(8'hff, i == 7, d, a);
      check("burst byte", {24'h0, d}, {24'h0, exp[i]});
    end
    m.i2c_stop();
    check("pointer", {16'h0, acc_addr}, 32'he881);
    check("read pulses", rd_cnt, 32'h2);
  endtask
  task automatic spi_test;
    logic [63:0] rx, oe;
    check("two-wire default", {31'h0, spi_mode}, 32'h0);
    repeat (3) m.sel_pulse();
    repeat (8) @(posedge core_clk);
    check("four-wire chosen", {31'h0, spi_mode}, 32'h1);
    m.spi_frame({8'h01, 16'h4321, 40'h0}, 40, rx, oe);
    check("read data", {16'h0, rx[39:24]}, 32'hde21);
    check("out enable", {30'h0, oe[40:39]}, 32'h1);
    #1 check("released", {31'h0, so_oe}, 32'h0);
    m.spi_frame({8'h81, 16'he880, 40'h0}, 30, rx, oe);
    check("abort data", {26'h0, rx[39:34]}, 32'h20);
    #1 check("abort float", {31'h0, so_oe}, 32'h0);
    m.spi_frame({8'h00, 16'h2222, 8'h5a, 32'h0}, 32, rx, oe);
    repeat (10) @(posedge core_clk);
    check("write quiet", {31'h0, |oe}, 32'h0);
    check("spi write addr", {16'h0, wr_addr}, 32'h2222);
    check("spi write data", wr_data, 32'h5a);
  endtask
  task automatic reset_test;
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    check("mode after reset", {31'h0, spi_mode}, 32'h0);
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    i2c_write_test();
    i2c_burst_test();
    spi_test();
    reset_test();
    stop_test();
  end
endmodule
